// ---- include/pesr_pkg.sv ----
// Package: register map, field layout, codes and reset values of the diagnostics readout
package pesr_pkg;
    // Register offsets (word addresses on the serial control port)
    localparam logic [7:0] PESR_ADDR_CHECKER_STATE = 8'h8a;
    localparam logic [7:0] PESR_ADDR_ERROR_TALLY = 8'h89;
    localparam logic [7:0] PESR_ADDR_SEGMENT_SIZE = 8'h8b;
    localparam logic [7:0] PESR_ADDR_SHAPE_LEFT = 8'h8c;
    localparam logic [7:0] PESR_ADDR_SHAPE_TOP = 8'h8d;
    localparam logic [7:0] PESR_ADDR_SHAPE_RIGHT = 8'h8e;
    // Field positions
    localparam int PESR_STATE_LSB = 0;
    localparam int PESR_ABORT_BIT = 8;
    localparam int PESR_NODATA_BIT = 9;
    localparam int PESR_OFFSET_LSB = 8;
    localparam int PESR_PHASE_LSB = 0;
    // Limits and reset values
    localparam logic [7:0] PESR_PHASE_MAX = 8'h7f;
    localparam logic [7:0] PESR_OFFSET_ZERO_V = 8'h7f;
    localparam logic [15:0] PESR_RESET_WORD = 16'h0000;
    localparam logic [15:0] PESR_SHAPE_RESET = 16'h7f00;
    localparam int PESR_EDGE_COUNT = 3;

    // Checker state codes
    typedef enum logic [1:0] {
        PESR_CHK_IDLE = 2'h0,
        PESR_CHK_BUSY = 2'h1,
        PESR_CHK_DONE = 2'h2,
        PESR_CHK_ABORT = 2'h3
    } pesr_chk_code_t;

    // Handshake phase of the checker control
    typedef enum logic [1:0] {
        PESR_PH_IDLE,
        PESR_PH_RUN,
        PESR_PH_DONE,
        PESR_PH_ABORT
    } pesr_phase_t;
endpackage

// ---- include/pesr_shape_if.sv ----
// Interface: shape scan result capture between the readout and its edge store
interface pesr_shape_if;
    logic capture;
    logic [7:0] offset [3];
    logic [7:0] phase [3];
    logic [15:0] word [3];
    modport store (input capture, input offset, input phase, output word);
    modport top (output capture, output offset, output phase, input word);
endinterface

// ---- src/pesr_shape_store.sv ----
// Module: holding registers for the three edge shape scan results
module pesr_shape_store (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    pesr_shape_if.store sh
);
    import pesr_pkg::*;

    logic [15:0] word_r [PESR_EDGE_COUNT];
    logic [15:0] word_nxt [PESR_EDGE_COUNT];

    // One holding register per edge, left then top then right
    genvar g;
    generate
        for (g = 0; g < PESR_EDGE_COUNT; g++) begin : g_edge
            // Next value: latch only on scan completion
            always_comb begin
                word_nxt[g] = word_r[g];
                if (sh.capture) begin
                    // Offset in upper byte, phase clamped to 0..127
                    word_nxt[g] = {sh.offset[g],
                        (sh.phase[g] > PESR_PHASE_MAX) ? PESR_PHASE_MAX : sh.phase[g]};
                end
            end
            // Register; reads never touch it
            always_ff @(posedge mclk) begin
                if (rst) begin
                    word_r[g] <= PESR_SHAPE_RESET;
                end else if (ce) begin
                    word_r[g] <= word_nxt[g];
                end
            end
            assign sh.word[g] = word_r[g];
        end
    endgenerate
endmodule

// ---- src/pesr_readout.sv ----
// Module: read-only diagnostics registers for checker state, segment size and eye shape
module pesr_readout (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Register read port
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [15:0] rd_data,
    output logic rd_valid,
    // Checker control and events
    input wire logic checker_go_request,
    input wire logic checker_timed,
    input wire logic checker_run_end,
    input wire logic [15:0] checker_error_count,
    input wire logic checker_no_data,
    input wire logic cdr_locked,
    input wire logic sleep,
    // Eye monitor results
    input wire logic segment_done,
    input wire logic [15:0] eye_segment_byte_count,
    input wire logic shape_done,
    input wire logic [7:0] left_offset,
    input wire logic [7:0] left_phase,
    input wire logic [7:0] top_offset,
    input wire logic [7:0] top_phase,
    input wire logic [7:0] right_offset,
    input wire logic [7:0] right_phase,
    // Live state for the checker engine
    output logic checker_active
);
    import pesr_pkg::*;

    // Overview of the block
    //
    // Six read-only words sit behind the register read port.
    // Tally word holds the checker error count of the last run if it was a completed timed run, else zero.
    // State word holds the two-bit checker code plus abort and no-data flags.
    // Segment word holds the byte count of the last partial scan segment.
    // Three shape words hold offset and phase of left, top and right edges.
    //
    // Checker handshake
    //
    // Host raises go while the state code reads idle.
    // Device answers with busy, or with abort when unlocked or asleep.
    // A timed run ends by itself and reports done.
    // A continuous run never reports done.
    // It stays busy until the host drops go, which reports abort.
    // Lock loss or sleep during any run reports abort.
    // Host drops go after done or abort to return the code to idle.
    // A go raised again once idle is reached starts a fresh run.
    //
    // Error tally handling
    //
    // Tally clears to zero when a run is accepted.
    // Tally loads the engine count when a timed run completes.
    // After an abort the tally keeps whatever it held, which is zero.
    //
    // Flags in the state word
    //
    // Abort flag follows the outcome of the last accepted request.
    // It stays until the next request is accepted.
    // No-data flag loads with the count on completion.
    // It clears when the next request is accepted.
    //
    // Clock enable
    //
    // Every register in the block, synchronisers included, holds while ce is low.
    // A read presented while ce is low is simply not taken.
    //
    // Hazards
    //
    // Lock and sleep are asynchronous and reach the state logic two edges late.
    // A go raised within two edges of lock returning will still abort.
    // Abort wins over run end when both fall in one cycle.

    // Two-stage synchronisers for lock and sleep, which come from analog blocks
    logic [1:0] lock_sync_r, lock_sync_nxt;
    logic [1:0] sleep_sync_r, sleep_sync_nxt;
    logic lock_ok, asleep;

    // Checker state group
    pesr_phase_t phase_r, phase_nxt;       // Handshake phase
    logic timed_r, timed_nxt;              // Run is timed
    logic abort_r, abort_nxt;              // Last run aborted
    logic nodata_r, nodata_nxt;            // No transitions seen
    logic [15:0] checker_error_tally_r, checker_error_tally_nxt;
    logic [15:0] seg_r, seg_nxt;           // Segment byte count
    logic [1:0] checker_run_state;         // Reported state code

    // Read port group
    logic [15:0] rd_data_r, rd_data_nxt;
    logic rd_valid_r, rd_valid_nxt;

    pesr_shape_if sh ();

    // Synchroniser next values; first stage only feeds the second
    always_comb begin
        lock_sync_nxt = {lock_sync_r[0], cdr_locked};
        sleep_sync_nxt = {sleep_sync_r[0], sleep};
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            lock_sync_r <= 2'h0;
            sleep_sync_r <= 2'h0;
        end else if (ce) begin
            lock_sync_r <= lock_sync_nxt;
            sleep_sync_r <= sleep_sync_nxt;
        end
    end

    assign lock_ok = lock_sync_r[1];
    assign asleep = sleep_sync_r[1];

    // Map handshake phase to the reported code
    function automatic logic [1:0] code_of(input pesr_phase_t p);
        case (p)
            PESR_PH_IDLE: code_of = PESR_CHK_IDLE;
            PESR_PH_RUN: code_of = PESR_CHK_BUSY;
            PESR_PH_DONE: code_of = PESR_CHK_DONE;
            PESR_PH_ABORT: code_of = PESR_CHK_ABORT;
            default: code_of = PESR_CHK_IDLE;
        endcase
    endfunction

    // Checker handshake: go raised -> run -> done/abort; go dropped -> idle
    always_comb begin
        phase_nxt = phase_r;
        timed_nxt = timed_r;
        abort_nxt = abort_r;
        nodata_nxt = nodata_r;
        checker_error_tally_nxt = checker_error_tally_r;
        case (phase_r)
            PESR_PH_IDLE: begin
                // Host requests a run
                if (checker_go_request) begin
                    timed_nxt = checker_timed;
                    nodata_nxt = 1'b0;
                    checker_error_tally_nxt = PESR_RESET_WORD;
                    if (!lock_ok || asleep) begin
                        // Condition already present at request
                        phase_nxt = PESR_PH_ABORT;
                        abort_nxt = 1'b1;
                    end else begin
                        phase_nxt = PESR_PH_RUN;
                        abort_nxt = 1'b0;
                    end
                end
            end
            PESR_PH_RUN: begin
                if (!lock_ok || asleep) begin
                    // Lock lost or sleep during run
                    phase_nxt = PESR_PH_ABORT;
                    abort_nxt = 1'b1;
                end else if (!checker_go_request && !timed_r) begin
                    // Host stops a continuous run; reported as abort
                    phase_nxt = PESR_PH_ABORT;
                    abort_nxt = 1'b1;
                end else if (checker_run_end && timed_r) begin
                    // Only timed runs complete
                    phase_nxt = PESR_PH_DONE;
                    checker_error_tally_nxt = checker_error_count;
                    nodata_nxt = checker_no_data;
                end
            end
            PESR_PH_DONE, PESR_PH_ABORT: begin
                // Host drops go to close the handshake
                if (!checker_go_request) begin
                    phase_nxt = PESR_PH_IDLE;
                end
            end
            default: phase_nxt = PESR_PH_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_r <= PESR_PH_IDLE;
            timed_r <= 1'b0;
            abort_r <= 1'b0;
            nodata_r <= 1'b0;
            checker_error_tally_r <= PESR_RESET_WORD;
        end else if (ce) begin
            phase_r <= phase_nxt;
            timed_r <= timed_nxt;
            abort_r <= abort_nxt;
            nodata_r <= nodata_nxt;
            checker_error_tally_r <= checker_error_tally_nxt;
        end
    end

    // Two-bit state code
    assign checker_run_state = code_of(phase_r);
    assign checker_active = (phase_r == PESR_PH_RUN);

    // Segment byte count captured on each partial segment
    always_comb begin
        seg_nxt = segment_done ? eye_segment_byte_count : seg_r;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            seg_r <= PESR_RESET_WORD;
        end else if (ce) begin
            seg_r <= seg_nxt;
        end
    end

    // Shape results to the edge store, in left, top, right order
    assign sh.capture = shape_done;
    assign sh.offset[0] = left_offset;
    assign sh.offset[1] = top_offset;
    assign sh.offset[2] = right_offset;
    assign sh.phase[0] = left_phase;
    assign sh.phase[1] = top_phase;
    assign sh.phase[2] = right_phase;

    pesr_shape_store u_store (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .sh(sh.store)
    );

    // Read port behaviour
    //
    // A read is taken at a rising edge with ce and rd_en high.
    // The word appears on rd_data one edge later, with rd_valid.
    // The valid flag stands one cycle; the data stands until the next read.
    // Reads may follow one another back to back.
    // Reads never change any result register.
    // Unmapped addresses answer zero so software sees no stale data.
    //
    // Word layout
    //
    // State word: code in the low two bits, abort flag, then no-data flag.
    // All other bits of the state word read as zero.
    // Shape words: voltage offset in the upper byte, phase in the lower.
    // Offset code 127 means zero volts at the slicer.
    // Phase never exceeds 127; larger engine values are clamped on capture.
    //
    // Timing note
    //
    // Data is taken from the registers as they stand at the taking edge.
    // A result captured at that same edge shows up on the next read.

    // Read decode; unmapped addresses return zero
    always_comb begin
        rd_valid_nxt = rd_en;
        rd_data_nxt = rd_data_r;
        if (rd_en) begin
            case (rd_addr)
                PESR_ADDR_ERROR_TALLY: rd_data_nxt = checker_error_tally_r;
                PESR_ADDR_CHECKER_STATE: begin
                    // Reserved bits read as zero
                    rd_data_nxt = PESR_RESET_WORD;
                    rd_data_nxt[PESR_STATE_LSB +: 2] = checker_run_state;
                    rd_data_nxt[PESR_ABORT_BIT] = abort_r;
                    rd_data_nxt[PESR_NODATA_BIT] = nodata_r;
                end
                PESR_ADDR_SEGMENT_SIZE: rd_data_nxt = seg_r;
                PESR_ADDR_SHAPE_LEFT: rd_data_nxt = sh.word[0];
                PESR_ADDR_SHAPE_TOP: rd_data_nxt = sh.word[1];
                PESR_ADDR_SHAPE_RIGHT: rd_data_nxt = sh.word[2];
                default: rd_data_nxt = PESR_RESET_WORD;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_data_r <= PESR_RESET_WORD;
            rd_valid_r <= 1'b0;
        end else if (ce) begin
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
endmodule

// ---- testbench/pesr_readout_assertions.sv ----
// Checker: port assertions for the diagnostics readout
module pesr_readout_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic checker_go_request,
    input wire logic cdr_locked,
    input wire logic sleep,
    input wire logic checker_active
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Every taken read answers next cycle
    a_read_answer: assert property (ce && rd_en |=> rd_valid) else $error("read not answered");
    // Without a read, no answer and data holds
    a_read_hold: assert property (ce && !rd_en |=> !rd_valid && $stable(rd_data)) else $error("data moved");
    // Clock enable low freezes state
    a_freeze_state: assert property (!ce |=> $stable(rd_valid) && $stable(checker_active)) else $error("moved");
    // Unmapped words read zero
    a_unmapped_zero: assert property (
        ce && rd_en && !(rd_addr inside {[8'h89:8'h8e]}) |=> rd_data == 16'h0000) else $error("unmapped not zero");
    // Busy code agrees with the live flag
    a_busy_code: assert property (
        ce && rd_en && rd_addr == 8'h8a |=> (rd_data[1:0] == 2'h1) == $past(checker_active)) else $error("busy code");
    // Edge phase stays within 0..127
    a_phase_range: assert property (
        ce && rd_en && rd_addr inside {[8'h8c:8'h8e]} |=> rd_data[7:0] <= 8'h7f) else $error("phase too big");
    // A run starts only on request
    a_start_go: assert property ($rose(checker_active) |-> $past(checker_go_request)) else $error("no go");
    // Lock loss or sleep stops a run
    a_lock_abort: assert property ((ce && !cdr_locked) [*3] |=> !checker_active) else $error("no lock abort");
    a_sleep_abort: assert property ((ce && sleep) [*3] |=> !checker_active) else $error("no sleep abort");
endmodule
bind pesr_readout pesr_readout_assertions u_pesr_readout_assertions (.mclk, .rst, .ce, .rd_en, .rd_addr, .rd_data,
    .rd_valid, .checker_go_request, .cdr_locked, .sleep, .checker_active);

// ---- testbench/pesr_readout_tb.sv ----
// Testbench: register read-back of the diagnostics readout
module pesr_readout_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pesr_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, rd_en = 1'b0, rd_valid, checker_active;
    logic checker_go_request = 1'b0, checker_timed = 1'b1, checker_run_end = 1'b0, checker_no_data = 1'b0;
    logic cdr_locked = 1'b0, sleep = 1'b0, segment_done = 1'b0, shape_done = 1'b0;
    logic [7:0] rd_addr = 8'h00, left_offset = 8'h00, left_phase = 8'h90, top_offset = 8'h7f, top_phase = 8'h7f;
    logic [7:0] right_offset = 8'hff, right_phase = 8'h00;
    logic [15:0] rd_data, checker_error_count = 16'h1234, eye_segment_byte_count = 16'hffff;
    int failures = 0, num_checks = 0, cycles = 0;
    pesr_readout u_pesr_readout (.mclk, .rst, .ce, .rd_en, .rd_addr, .rd_data, .rd_valid, .checker_go_request,
        .checker_timed, .checker_run_end, .checker_error_count, .checker_no_data, .cdr_locked, .sleep, .segment_done,
        .eye_segment_byte_count, .shape_done, .left_offset, .left_phase, .top_offset, .top_phase, .right_offset,
        .right_phase, .checker_active);
    // Clock and cycle ceiling
    initial begin
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            conclude();
        end
    end
    // Verdict and end of run
    task automatic conclude();
        if (failures == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Word compare
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One read, judged at the edge after its answer, while the data still stands
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge mclk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        @(posedge mclk);
        chk(rd_data, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Reset values and unmapped words
    task automatic t_reset();
        rd(8'h8a, 16'h0000);
        rd(8'h89, 16'h0000);
        rd(8'h8b, 16'h0000);
        for (int i = 0; i < PESR_EDGE_COUNT; i++) rd(8'h8c + 8'(i), PESR_SHAPE_RESET);
        rd(8'h88, 16'h0000);
        rd(8'h8f, 16'h0000);
    endtask
    // Shape capture, clamp, hold; segment size; frozen read
    task automatic t_eye();
        shape_done <= 1'b1;
        segment_done <= 1'b1;
        tick(1);
        shape_done <= 1'b0;
        segment_done <= 1'b0;
        left_offset <= 8'h55;
        rd(8'h8c, 16'h007f);
        rd(8'h8d, 16'h7f7f);
        rd(8'h8e, 16'hff00);
        rd(8'h8c, 16'h007f);
        rd(8'h8b, 16'hffff);
        ce <= 1'b0;
        rd_en <= 1'b1;
        tick(1);
        rd_en <= 1'b0;
        tick(1);
        chk({15'h0000, rd_valid}, 16'h0000);
        ce <= 1'b1;
    endtask
    // Request while unlocked, then timed, continuous and lock-loss runs
    task automatic t_checker();
        checker_go_request <= 1'b1;
        tick(3);
        rd(8'h8a, 16'h0103);
        checker_go_request <= 1'b0;
        cdr_locked <= 1'b1;
        tick(3);
        rd(8'h8a, 16'h0100);
        checker_go_request <= 1'b1;
        tick(2);
        rd(8'h8a, 16'h0001);
        chk({15'h0000, checker_active}, 16'h0001);
        checker_run_end <= 1'b1;
        checker_no_data <= 1'b1;
        tick(1);
        checker_run_end <= 1'b0;
        checker_no_data <= 1'b0;
        rd(8'h8a, 16'h0202);
        rd(8'h89, 16'h1234);
        checker_go_request <= 1'b0;
        checker_timed <= 1'b0;
        tick(2);
        rd(8'h8a, 16'h0200);
        checker_go_request <= 1'b1;
        tick(2);
        rd(8'h89, 16'h0000);
        checker_run_end <= 1'b1;
        tick(1);
        checker_run_end <= 1'b0;
        rd(8'h8a, 16'h0001);
        sleep <= 1'b1;
        tick(4);
        rd(8'h8a, 16'h0103);
        sleep <= 1'b0;
        checker_go_request <= 1'b0;
        checker_timed <= 1'b1;
        tick(3);
        checker_go_request <= 1'b1;
        tick(2);
        cdr_locked <= 1'b0;
        tick(4);
        rd(8'h8a, 16'h0103);
    endtask
    // Main sequence
    initial begin
        tick(8);
        rst <= 1'b0;
        t_reset();
        t_eye();
        t_checker();
        conclude();
    end
endmodule
